// [fmsp_pkg.sv]
/*
 * Constants, state encodings and the state record of the four-mode serial port.
 * Assumes one 50 MHz clock and an APB master with 32-bit data.
 */
`default_nettype none
package fmsp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_BUF   = 8'h04;
    localparam logic [7:0] OFF_POWER = 8'h08;
    localparam logic [7:0] OFF_SLAVE_ADDRESS_REG = 8'h0C;
    localparam logic [7:0] OFF_SLAVE_ADDRESS_MASK_REG = 8'h10;

    // Control register fields, and the doubler bit of the power register
    localparam int B_MODE_HI = 7;
    localparam int B_MODE_LO = 6;
    localparam int B_MPF     = 5;
    localparam int B_REN     = 4;
    localparam int B_TB8     = 3;
    localparam int B_RB8     = 2;
    localparam int B_TI      = 1;
    localparam int B_RI      = 0;
    localparam int B_BAUD_DOUBLER_BIT    = 7;

    // Reset values of the address registers
    localparam logic [7:0] SLAVE_ADDRESS_REG_RST = 8'h00;
    localparam logic [7:0] SLAVE_ADDRESS_MASK_REG_RST = 8'h00;

    // Mode select codes
    localparam logic [1:0] MODE_SYNC    = 2'b00;
    localparam logic [1:0] MODE_ASYNC10 = 2'b01;
    localparam logic [1:0] MODE_ASYNC9F = 2'b10;
    localparam logic [1:0] MODE_ASYNC9T = 2'b11;

    // Synchronous shift clock: last phase and rising-edge phase
    localparam logic [3:0] M0_LAST12 = 4'hB;
    localparam logic [3:0] M0_HALF12 = 4'h6;
    localparam logic [3:0] M0_LAST4  = 4'h3;
    localparam logic [3:0] M0_HALF4  = 4'h2;
    localparam logic [3:0] M0_BITS   = 4'h7;

    // Fixed-rate prescaler: 16x tick every 4 (baud /64) or 2 (baud /32) clocks
    localparam logic [1:0] PRE_LAST64 = 2'h3;
    localparam logic [1:0] PRE_LAST32 = 2'h1;

    // Divide-by-16 bit timing, sample states 7th, 8th and 9th
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] SMP1     = 4'h6;
    localparam logic [3:0] SMP2     = 4'h7;
    localparam logic [3:0] SMP3     = 4'h8;

    // Data bits sent and index of the stop bit on receive
    localparam logic [3:0] NBITS8  = 4'h8;
    localparam logic [3:0] NBITS9  = 4'h9;
    localparam logic [3:0] RXEND10 = 4'h9;
    localparam logic [3:0] RXEND11 = 4'hA;

    typedef enum logic {RX_IDLE = 1'b0, RX_RUN = 1'b1} fmsp_rx_t;
    typedef enum logic [1:0] {M0_IDLE = 2'b00, M0_TX = 2'b01, M0_RX = 2'b10} fmsp_m0_t;

    typedef struct packed {
        logic [1:0] mode;
        logic       mpf, ren, tb8, rb8, ti, ri, baud_doubler_bit;
        logic [7:0] slave_address_reg, slave_address_mask_reg, serial_buffer, rdata;
        logic [1:0] pre;
        logic [3:0] txdiv;
        logic       txpend, txbusy;
        logic [3:0] txcnt;
        logic [8:0] txsh;
        logic       txd;
        fmsp_rx_t   rxst;
        logic [3:0] rxdiv;
        logic       rxprev;
        logic [1:0] smp;
        logic [3:0] rxcnt;
        logic [8:0] rxsh;
        fmsp_m0_t   m0st;
        logic [3:0] m0ph, m0cnt;
        logic [7:0] m0sh;
        logic       m0out;
    } fmsp_state_t;

    localparam fmsp_state_t STATE_RST = '{slave_address_reg: SLAVE_ADDRESS_REG_RST, slave_address_mask_reg: SLAVE_ADDRESS_MASK_REG_RST, txd: 1'b1,
        rxprev: 1'b1, rxst: RX_IDLE, m0st: M0_IDLE, default: '0};
endpackage
`default_nettype wire

// [fmsp_serial_port.sv]
/*
 * Four-mode serial port with APB register access: synchronous shifter and
 * three asynchronous frame formats with majority sampling and address filter.
 * Assumes all inputs synchronous to pclk and a timer overflow pulse for the
 * variable-rate modes.
 */
`default_nettype none

// Summary of operation
// - Two mode bits select four frame modes
// - Sync mode: data on rxd, clock on txd
// - Sync clock is pclk/12 or pclk/4
// - Buffer write sends; shift on falling edge
// - Sync receive when enabled and done clear
// - Mode 1 frame: start, 8 data, stop
// - Mode 1 rate is timer overflow/16
// - Transmit starts after next 16-count rollover
// - Done flag set when stop bit starts
// - Receive enabled; falling edge resets divider
// - Majority of samples 7, 8 and 9
// - Bad start bit aborts reception
// - Mode 1 load needs done clear, stop check
// - Mode 2 frame carries ninth bit
// - Mode 2 rate pclk/32 or pclk/64
// - Buffer write also loads ninth bit
// - Mode 2 done at eleventh rollover
// - Mode 2 load needs address match
// - Doubler bit 0 gives /64, 1 gives /32
// - Mode 3 is mode 2 with timer rate
// - Address mask selects compared bits
module fmsp_serial_port
    import fmsp_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Baud source
    input  wire logic        timer_ovf_tick,
    // Serial pins
    input  wire logic        rxd_i,
    output logic             rxd_o,
    output logic             rxd_oe_n,
    output logic             txd_o
);
    fmsp_state_t q;
    fmsp_state_t d;
    logic       acc;
    logic       wr;
    logic       setup;
    logic       mapped;
    logic       wr_ctrl;
    logic       wr_buf;
    logic       is_m0;
    logic       fixed;
    logic [1:0] pre_last;
    logic       tick;
    logic       tx_roll;
    logic [3:0] nbits;
    logic [3:0] m0_last;
    logic [3:0] m0_half;
    logic       m0_wrap;
    logic       maj;
    logic       match;
    logic [3:0] rx_last;
    logic       rx_mid;
    logic       rx_end;
    logic       ld_ok;

    // Bus decode; zero wait states so pready is a constant
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign setup   = psel & ~penable;
    assign mapped  = paddr inside {OFF_CTRL, OFF_BUF, OFF_POWER, OFF_SLAVE_ADDRESS_REG, OFF_SLAVE_ADDRESS_MASK_REG};
    assign wr_ctrl = wr & (paddr == OFF_CTRL);
    assign wr_buf  = wr & (paddr == OFF_BUF);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = {24'h0000_00, q.rdata};

    // Rate selection per mode
    assign is_m0    = (q.mode == MODE_SYNC);
    assign fixed    = (q.mode == MODE_ASYNC9F);
    assign pre_last = q.baud_doubler_bit ? PRE_LAST32 : PRE_LAST64;
    // Timer modes take the overflow pulse as the 16x tick
    assign tick     = fixed ? (q.pre == pre_last) : timer_ovf_tick;
    assign tx_roll  = tick & (q.txdiv == OVS_LAST);
    assign nbits    = q.mode[1] ? NBITS9 : NBITS8;
    assign m0_last  = q.mpf ? M0_LAST4 : M0_LAST12;
    assign m0_half  = q.mpf ? M0_HALF4 : M0_HALF12;
    assign m0_wrap  = (q.m0ph == m0_last);

    // Receive decisions
    assign maj     = (q.smp[0] & q.smp[1]) | (q.smp[0] & rxd_i) | (q.smp[1] & rxd_i);
    assign match   = ((q.rxsh[7:0] ^ q.slave_address_reg) & q.slave_address_mask_reg) == 8'h00;
    assign rx_last = q.mode[1] ? RXEND11 : RXEND10;
    assign rx_mid  = tick & (q.rxst == RX_RUN) & (q.rxdiv == SMP3);
    assign rx_end  = rx_mid & (q.rxcnt == rx_last);
    // Ninth bit gate for 11-bit frames, stop bit gate for 10-bit frames
    assign ld_ok   = rx_end & ~q.ri & (~q.mpf | (q.mode[1] ? (q.rxsh[8] & match) : maj));

    // Pins; the sync clock idles high and is low for the first half period
    assign rxd_o    = q.m0out;
    assign rxd_oe_n = (q.m0st != M0_TX);
    assign txd_o    = is_m0 ? ((q.m0st == M0_IDLE) | (q.m0ph >= m0_half)) : q.txd;

    // Next-state logic; hardware sets come after software writes so a set wins
    always_comb begin
        d = q;
        // Read data captured in the setup phase, shown in the access phase
        if (setup) begin
            unique case (paddr)
                OFF_CTRL:  d.rdata = {q.mode, q.mpf, q.ren, q.tb8, q.rb8, q.ti, q.ri};
                OFF_BUF:   d.rdata = q.serial_buffer;
                OFF_POWER: d.rdata = {q.baud_doubler_bit, 7'h00};
                OFF_SLAVE_ADDRESS_REG: d.rdata = q.slave_address_reg;
                OFF_SLAVE_ADDRESS_MASK_REG: d.rdata = q.slave_address_mask_reg;
                default:   d.rdata = 8'h00;
            endcase
        end
        // Register writes
        if (wr_ctrl) begin
            d.mode = pwdata[B_MODE_HI:B_MODE_LO];
            d.mpf  = pwdata[B_MPF];
            d.ren  = pwdata[B_REN];
            d.tb8  = pwdata[B_TB8];
            d.rb8  = pwdata[B_RB8];
            d.ti   = pwdata[B_TI];
            d.ri   = pwdata[B_RI];
        end
        if (wr & (paddr == OFF_POWER)) begin
            d.baud_doubler_bit = pwdata[B_BAUD_DOUBLER_BIT];
        end
        if (wr & (paddr == OFF_SLAVE_ADDRESS_REG)) begin
            d.slave_address_reg = pwdata[7:0];
        end
        if (wr & (paddr == OFF_SLAVE_ADDRESS_MASK_REG)) begin
            d.slave_address_mask_reg = pwdata[7:0];
        end

        // Fixed-rate prescaler, idle outside the fixed mode
        d.pre = (fixed && q.pre != pre_last) ? q.pre + 2'h1 : 2'h0;

        // Asynchronous transmitter, frame aligned to the free 16-count
        if (tick) begin
            d.txdiv = q.txdiv + 4'h1;
        end
        if (wr_buf && !is_m0 && !q.txpend && !q.txbusy) begin
            d.txpend = 1'b1;
            // Stop level takes the ninth slot in 10-bit frames
            d.txsh   = {(q.mode[1] ? q.tb8 : 1'b1), pwdata[7:0]};
        end
        if (tx_roll && !is_m0) begin
            if (q.txpend) begin
                d.txpend = 1'b0;
                d.txbusy = 1'b1;
                d.txd    = 1'b0;
                d.txcnt  = 4'h0;
            end else if (q.txbusy) begin
                d.txcnt = q.txcnt + 4'h1;
                if (q.txcnt < nbits) begin
                    d.txd  = q.txsh[0];
                    d.txsh = {1'b1, q.txsh[8:1]};
                end else if (q.txcnt == nbits) begin
                    d.txd = 1'b1;
                    d.ti  = 1'b1;
                end else begin
                    d.txbusy = 1'b0;
                end
            end
        end

        // Asynchronous receiver
        if (tick) begin
            d.rxprev = rxd_i;
        end
        if (is_m0 || !q.ren) begin
            d.rxst = RX_IDLE;
        end else if (q.rxst == RX_IDLE) begin
            if (tick && q.rxprev && !rxd_i) begin
                d.rxst  = RX_RUN;
                d.rxdiv = 4'h0;
                d.rxcnt = 4'h0;
            end
        end else if (tick) begin
            d.rxdiv = q.rxdiv + 4'h1;
            if (q.rxdiv == SMP1) begin
                d.smp[0] = rxd_i;
            end
            if (q.rxdiv == SMP2) begin
                d.smp[1] = rxd_i;
            end
            if (q.rxdiv == OVS_LAST) begin
                d.rxcnt = q.rxcnt + 4'h1;
            end
            if (q.rxdiv == SMP3) begin
                if (q.rxcnt == 4'h0) begin
                    if (maj) begin
                        d.rxst = RX_IDLE;
                    end
                end else if (q.rxcnt == rx_last) begin
                    // Stop bit judged; back to hunting for an edge
                    d.rxst = RX_IDLE;
                    if (ld_ok) begin
                        d.serial_buffer = q.rxsh[7:0];
                        d.rb8  = q.mode[1] ? q.rxsh[8] : maj;
                        d.ri   = 1'b1;
                    end
                end else begin
                    d.rxsh[q.rxcnt - 4'h1] = maj;
                end
            end
        end

        // Synchronous shifter; half duplex, so one state machine serves both ways
        unique case (q.m0st)
            M0_IDLE: begin
                if (is_m0 && wr_buf) begin
                    d.m0st  = M0_TX;
                    d.m0ph  = 4'h0;
                    d.m0cnt = 4'h0;
                    d.m0sh  = pwdata[7:0];
                    d.m0out = pwdata[0];
                end else if (is_m0 && q.ren && !q.ri) begin
                    d.m0st  = M0_RX;
                    d.m0ph  = 4'h0;
                    d.m0cnt = 4'h0;
                end
            end
            M0_TX, M0_RX: begin
                d.m0ph = m0_wrap ? 4'h0 : q.m0ph + 4'h1;
                if (q.m0st == M0_RX && q.m0ph == m0_half) begin
                    d.m0sh = {rxd_i, q.m0sh[7:1]};
                end
                if (m0_wrap) begin
                    d.m0cnt = q.m0cnt + 4'h1;
                    if (q.m0st == M0_TX) begin
                        // Falling edge: shift right with zero fill
                        d.m0sh  = {1'b0, q.m0sh[7:1]};
                        d.m0out = q.m0sh[1];
                    end
                    if (q.m0cnt == M0_BITS) begin
                        d.m0st = M0_IDLE;
                        if (q.m0st == M0_TX) begin
                            d.ti = 1'b1;
                        end else begin
                            d.serial_buffer = q.m0sh;
                            d.ri   = 1'b1;
                        end
                    end
                end
                if (!is_m0) begin
                    d.m0st = M0_IDLE;
                end
            end
            default: begin
                d.m0st = M0_IDLE;
            end
        endcase
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_m0_tx_start: assert property (is_m0 && q.m0st == M0_IDLE && wr_buf
        |=> q.m0st == M0_TX)
        else $error("sync transmit did not start after buffer write");
    a_m0_rx_start: assert property (is_m0 && q.m0st == M0_IDLE && !wr_buf && q.ren && !q.ri
        |=> q.m0st == M0_RX)
        else $error("sync receive did not start");
    a_m0_drive: assert property (q.m0st == M0_TX |-> !rxd_oe_n && rxd_o == q.m0sh[0])
        else $error("data pin not driven while sending");
    a_sclk_div12: assert property (is_m0 && !q.mpf && q.m0st == M0_TX && q.m0ph == 4'h0
        && $stable(q.mode) |-> !txd_o [*6] ##1 txd_o)
        else $error("shift clock low phase wrong");
    a_pre_div64: assert property (fixed && !q.baud_doubler_bit && tick && $stable(q.baud_doubler_bit)
        |=> !tick [*3] ##1 tick)
        else $error("fixed rate tick spacing wrong");
    a_start_bit: assert property (!is_m0 && tx_roll && q.txpend |=> !txd_o && q.txbusy)
        else $error("start bit not sent at rollover");
    a_stop_flag: assert property (!is_m0 && tx_roll && q.txbusy && q.txcnt == nbits
        |=> q.ti && txd_o)
        else $error("done flag not set with stop bit");
    a_rx_abort: assert property (rx_mid && q.rxcnt == 4'h0 && maj && q.ren && !is_m0
        |=> q.rxst == RX_IDLE)
        else $error("bad start bit not aborted");
    a_ri_hold: assert property (q.ri && !wr_ctrl && !wr |=> q.ri && $stable(q.serial_buffer))
        else $error("buffer changed while receive flag set");
    a_addr_filt: assert property (ld_ok && q.mpf && q.mode[1] |-> match && q.rxsh[8])
        else $error("frame accepted without address match");
    a_edge_reset: assert property (!is_m0 && q.ren && q.rxst == RX_IDLE && tick
        && q.rxprev && !rxd_i |=> q.rxst == RX_RUN && q.rxdiv == 4'h0)
        else $error("falling edge did not reset divider");

    c_m0_tx_done: cover property (q.m0st == M0_TX ##[1:200] q.m0st == M0_IDLE && q.ti);
    c_async_load: cover property (ld_ok && !q.mode[1]);
    c_addr_load: cover property (ld_ok && q.mpf && fixed);
    c_rx_abort: cover property (rx_mid && q.rxcnt == 4'h0 && maj);
endmodule
`default_nettype wire

// [fmsp_link_model.sv]
/*
 * Behavioural far-side serial device for the four-mode serial port: sends
 * asynchronous frames on the data pin and decodes what the port sends.
 * Assumes a bit time of BIT pclk cycles and a data line pulled high when idle.
 */
`default_nettype none
module fmsp_link_model #(
    parameter int BIT = 32
) (
    // Clock
    input  wire logic        pclk,
    // Device pins
    input  wire logic        txd_o,
    input  wire logic        rxd_o,
    input  wire logic        rxd_oe_n,
    output logic             rxd_i,
    // Decoder setup and result
    input  wire logic        sync_mode,
    input  wire logic [3:0]  nbits,
    output logic      [10:0] frame,
    output logic             got
);
    timeunit 1ns;
    timeprecision 1ps;

    logic drv = 1'b1;

    // Device wins while its enable is low; a released line follows our own drive level
    assign rxd_i = rxd_oe_n ? drv : rxd_o;

    // One frame, LSB first, one bit time per bit, then back to mark
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            drv <= f[i];
            repeat (BIT) @(posedge pclk);
        end
        drv <= 1'b1;
    endtask

    // Low pulse far shorter than half a bit: must not pass as a start bit
    task automatic glitch();
        drv <= 1'b0;
        repeat (4) @(posedge pclk);
        drv <= 1'b1;
    endtask

    // Decoder: mid-bit sampling for async, rising shift clock for sync
    initial begin
        got = 1'b0;
        frame = '0;
        forever begin
            @(negedge txd_o);
            frame = '0;
            if (sync_mode) begin
                for (int i = 0; i < 8; i++) begin
                    @(posedge txd_o);
                    // The line itself: the port's data when it drives, our level otherwise
                    frame[i] = rxd_i;
                    if (i < 7) @(negedge txd_o);
                end
            end else begin
                repeat (BIT / 2) @(posedge pclk);
                for (int i = 0; i < int'(nbits); i++) begin
                    frame[i] = txd_o;
                    if (i < int'(nbits) - 1) repeat (BIT) @(posedge pclk);
                end
            end
            @(posedge pclk);
            got <= 1'b1;
            @(posedge pclk);
            got <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
/*
 * Self-checking bench for the four-mode serial port: APB master tasks,
 * expectation queues checked by a monitor, and the far-side link model.
 * Assumes zero or more APB wait states and a 2-cycle timer overflow tick.
 */
`default_nettype none
module tb_top
    import fmsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, tick, sync_mode;
    logic [7:0]  paddr, d, ctl;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, rxd_i, rxd_o, rxd_oe_n, txd_o, got, f, ok, n9;
    logic [3:0]  nbits;
    logic [10:0] frame;
    logic [1:0]  m;
    logic [12:0] tbl [6];
    logic [32:0] rq [$];
    logic [10:0] fq [$];
    int          fail_count, comparisons, seed;

    always #10 pclk = ~pclk;

    // Timer overflow every second clock: bit time of 32 clocks
    always @(posedge pclk) tick <= presetn ? ~tick : 1'b0;

    fmsp_serial_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_ovf_tick(tick), .rxd_i(rxd_i), .rxd_o(rxd_o),
        .rxd_oe_n(rxd_oe_n), .txd_o(txd_o));
    fmsp_link_model #(.BIT(32)) u_link (.pclk(pclk), .txd_o(txd_o), .rxd_o(rxd_o),
        .rxd_oe_n(rxd_oe_n), .rxd_i(rxd_i), .sync_mode(sync_mode), .nbits(nbits),
        .frame(frame), .got(got));

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One APB transfer: setup, then access held until pready at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n == 100) begin
            fail_count++;
            $display("BAD %0t bus never answered", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        apb(a, 1'b1, {24'h0, v});
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask

    task automatic wait_tx();
        int n;
        n = 0;
        while (fq.size() != 0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n == 3000) begin
            fail_count++;
            $display("BAD %0t frame never seen", $time);
        end
        repeat (40) @(posedge pclk);
    endtask

    // Monitor: oldest note against each read answer and each decoded frame
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, rq.pop_front());
        if (got === 1'b1) check({22'h0, frame}, {22'h0, fq.pop_front()});
    end

    initial begin
        repeat (30000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        seed = 34;
        {presetn, psel, penable, pwrite, paddr, pwdata, sync_mode} = '0;
        nbits = 4'hA;
        // Mode, filter, accept, ninth or stop, byte
        tbl = '{{MODE_ASYNC10, 3'b011, 8'h00}, {MODE_ASYNC10, 3'b100, 8'h5A},
                {MODE_ASYNC9T, 3'b111, 8'hA5}, {MODE_ASYNC9T, 3'b100, 8'hA4},
                {MODE_ASYNC9T, 3'b101, 8'hB4}, {MODE_ASYNC9F, 3'b010, 8'h00}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFF_CTRL, 33'h0);
        rd(OFF_POWER, 33'h0);
        rd(OFF_SLAVE_ADDRESS_REG, {25'h0, SLAVE_ADDRESS_REG_RST});
        rd(OFF_SLAVE_ADDRESS_MASK_REG, {25'h0, SLAVE_ADDRESS_MASK_REG_RST});
        rd(8'h14, {1'b1, 32'h0});
        $display("test reset done");
        // Async transmit: mode 1, then mode 2 with both ninth-bit values
        wr(OFF_POWER, 8'h80);
        for (int k = 0; k < 3; k++) begin
            d = 8'($random(seed));
            m = (k == 0) ? MODE_ASYNC10 : MODE_ASYNC9F;
            ctl = {m, 2'b00, (k != 2), 3'b000};
            nbits <= (k == 0) ? 4'hA : 4'hB;
            wr(OFF_CTRL, ctl);
            fq.push_back({(k != 0), (k != 2), d, 1'b0});
            wr(OFF_BUF, d);
            wait_tx();
            rd(OFF_CTRL, {25'h0, ctl | 8'h02});
        end
        $display("test async transmit done");
        // Async receive through the stop check and the address filter
        wr(OFF_SLAVE_ADDRESS_REG, 8'hA4);
        wr(OFF_SLAVE_ADDRESS_MASK_REG, 8'hFA);
        for (int k = 0; k < 6; k++) begin
            {m, f, ok, n9, d} = tbl[k];
            if (!f) d = 8'($random(seed));
            ctl = {m, f, 1'b1, 4'b0000};
            wr(OFF_CTRL, ctl);
            u_link.send({1'b1, n9, d, 1'b0}, (m == MODE_ASYNC10) ? 10 : 11);
            repeat (4) @(posedge pclk);
            rd(OFF_CTRL, {25'h0, ok ? (ctl | {5'b0, n9, 2'b01}) : ctl});
            if (ok) rd(OFF_BUF, {25'h0, d});
        end
        $display("test async receive done");
        // Receiver off, then a short glitch, then a good frame
        ctl = {MODE_ASYNC10, 6'b000000};
        wr(OFF_CTRL, ctl);
        u_link.send(11'h3A5, 10);
        rd(OFF_CTRL, {25'h0, ctl});
        ctl = {MODE_ASYNC10, 6'b010000};
        wr(OFF_CTRL, ctl);
        u_link.glitch();
        repeat (64) @(posedge pclk);
        rd(OFF_CTRL, {25'h0, ctl});
        u_link.send(11'h3C2, 10);
        repeat (4) @(posedge pclk);
        rd(OFF_CTRL, {25'h0, ctl | 8'h05});
        rd(OFF_BUF, 33'h0E1);
        $display("test start bit done");
        // Sync transmit at both shift clock rates
        sync_mode <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            d = 8'($random(seed));
            ctl = {MODE_SYNC, r[0], 5'b00000};
            wr(OFF_CTRL, ctl);
            fq.push_back({3'b000, d});
            wr(OFF_BUF, d);
            wait_tx();
            rd(OFF_CTRL, {25'h0, ctl | 8'h02});
        end
        $display("test sync transmit done");
        // Sync receive with the line released high: eight ones come in
        ctl = {MODE_SYNC, 6'b010000};
        fq.push_back({3'b000, 8'hFF});
        wr(OFF_CTRL, ctl);
        wait_tx();
        rd(OFF_CTRL, {25'h0, ctl | 8'h01});
        rd(OFF_BUF, 33'h0FF);
        wr(OFF_CTRL, 8'h00);
        $display("test sync receive done");
        print_verdict();
    end
endmodule
`default_nettype wire
